// ---- shared/bdp_params.svh ----
/*
 Constants for the branch direction and target predictor.
 Assumes inclusion by bare name from every design file that needs it.
*/
`ifndef BDP_PARAMS_SVH
`define BDP_PARAMS_SVH
`define BDP_ADDR_W 32
`define BDP_RAS_DEPTH 16
`define BDP_BTB_ENTRIES 64
`define BDP_TC_ENTRIES 16
`define BDP_INSN_LEN_W 4
`endif

// ---- shared/bdp_pkg.sv ----
/*
 Types shared by the predictor modules.
 Assumes bdp_params.svh defines the address width.
*/
`include "bdp_params.svh"
package bdp_pkg;
   typedef enum logic [5:0] {
      BDP_BR_NONE = 6'h01,
      BDP_BR_COND = 6'h02,
      BDP_BR_UNCOND = 6'h04,
      BDP_BR_CALL = 6'h08,
      BDP_BR_RET = 6'h10,
      BDP_BR_IND = 6'h20
   } bdp_br_kind_t;

   typedef struct packed {
      logic valid;
      bdp_br_kind_t kind;
      logic indirect_call;
      logic [`BDP_ADDR_W-1:0] pc;
      logic [`BDP_INSN_LEN_W-1:0] len;
      logic [`BDP_ADDR_W-1:0] direct_target;
      logic next_is_undef;
   } bdp_req_t;

   typedef struct packed {
      logic valid;
      logic taken;
      logic [`BDP_ADDR_W-1:0] target;
      logic from_btb;
      logic from_ras;
      logic from_trace;
      logic stop_decode;
   } bdp_pred_t;

   typedef struct packed {
      logic valid;
      logic [`BDP_ADDR_W-1:0] pc;
      logic taken;
      logic [`BDP_ADDR_W-1:0] target;
   } bdp_upd_t;

   typedef struct packed {
      logic valid;
      logic [`BDP_ADDR_W-1:0] pc;
      logic [`BDP_ADDR_W-1:0] target;
   } bdp_tc_fill_t;
endpackage

// ---- hdl/bdp_ras.sv ----
/*
 Return address stack, circular, with overwrite of the oldest entry.
 Assumes push and pop are never asked in the same cycle by the caller.
*/
`timescale 1ns/1ps
`include "bdp_params.svh"
module bdp_ras #(
   parameter int DEPTH = `BDP_RAS_DEPTH,
   parameter int AW = `BDP_ADDR_W
) (
   input wire logic mclk_i,
   input wire logic rst_i,
   input wire logic push_i,
   input wire logic [AW-1:0] push_addr_i,
   input wire logic pop_i,
   output logic [AW-1:0] top_o,
   output logic empty_o
);
   localparam int PW = $clog2(DEPTH);
   localparam int CW = $clog2(DEPTH + 1);
   logic [AW-1:0] mem_reg [DEPTH];
   logic [PW-1:0] ptr_reg, ptr_next;
   logic [CW-1:0] cnt_reg, cnt_next;

   // Pointer and occupancy; full stack keeps count and overwrites oldest
   always_comb begin
      ptr_next = ptr_reg;
      cnt_next = cnt_reg;
      if (push_i) begin
         ptr_next = ptr_reg + 1'b1;
         if (cnt_reg != CW'(DEPTH)) begin
            cnt_next = cnt_reg + 1'b1;
         end
      end else if (pop_i && cnt_reg != '0) begin
         ptr_next = ptr_reg - 1'b1;
         cnt_next = cnt_reg - 1'b1;
      end
   end

   always_ff @(posedge mclk_i) begin
      if (rst_i) begin
         ptr_reg <= '0;
         cnt_reg <= '0;
      end else begin
         ptr_reg <= ptr_next;
         cnt_reg <= cnt_next;
      end
   end

   // Storage needs no reset; count guards stale slots
   always_ff @(posedge mclk_i) begin
      if (push_i) begin
         mem_reg[ptr_reg] <= push_addr_i;
      end
   end

   assign top_o = mem_reg[PW'(ptr_reg - 1'b1)];
   assign empty_o = (cnt_reg == '0);

   property p_ras_bound;
      @(posedge mclk_i) disable iff (rst_i)
      cnt_reg <= CW'(DEPTH);
   endproperty
   a_ras_bound: assert property (p_ras_bound)
      else $error("Return stack count above depth");

   property p_ras_lifo;
      @(posedge mclk_i) disable iff (rst_i)
      push_i |=> (top_o == $past(push_addr_i)) && !empty_o;
   endproperty
   a_ras_lifo: assert property (p_ras_lifo)
      else $error("Pushed address not on top");
endmodule // bdp_ras

// ---- hdl/bdp_btb.sv ----
/*
 Direct-mapped branch target buffer, one taken target per entry.
 Assumes updates come from branch resolution on the same clock.
*/
`timescale 1ns/1ps
`include "bdp_params.svh"
module bdp_btb #(
   parameter int ENTRIES = `BDP_BTB_ENTRIES,
   parameter int AW = `BDP_ADDR_W
) (
   input wire logic mclk_i,
   input wire logic rst_i,
   input wire logic [AW-1:0] look_pc_i,
   output logic hit_o,
   output logic [AW-1:0] target_o,
   input wire logic upd_i,
   input wire logic [AW-1:0] upd_pc_i,
   input wire logic [AW-1:0] upd_target_i
);
   localparam int IW = $clog2(ENTRIES);
   logic [ENTRIES-1:0] val_reg, val_next;
   logic [AW-1:0] tag_reg [ENTRIES];
   logic [AW-1:0] tgt_reg [ENTRIES];

   function automatic logic [IW-1:0] idx_of(input logic [AW-1:0] pc);
      idx_of = pc[IW-1:0];
   endfunction

   // Valid bits; an update always installs
   always_comb begin
      val_next = val_reg;
      if (upd_i) begin
         val_next[idx_of(upd_pc_i)] = 1'b1;
      end
   end

   always_ff @(posedge mclk_i) begin
      if (rst_i) begin
         val_reg <= '0;
      end else begin
         val_reg <= val_next;
      end
   end

   // Newest taken target replaces any older one
   always_ff @(posedge mclk_i) begin
      if (upd_i) begin
         tag_reg[idx_of(upd_pc_i)] <= upd_pc_i;
         tgt_reg[idx_of(upd_pc_i)] <= upd_target_i;
      end
   end

   assign hit_o = val_reg[idx_of(look_pc_i)] &&
                  tag_reg[idx_of(look_pc_i)] == look_pc_i;
   assign target_o = tgt_reg[idx_of(look_pc_i)];

   property p_btb_last;
      @(posedge mclk_i) disable iff (rst_i)
      upd_i ##1 (look_pc_i == $past(upd_pc_i)) |->
         hit_o && target_o == $past(upd_target_i);
   endproperty
   a_btb_last: assert property (p_btb_last)
      else $error("Buffer target is not the last one learned");
endmodule // bdp_btb

// ---- hdl/bdp_top.sv ----
/*
 Branch direction and target predictor top.
 Assumes one request per cycle from fetch and decode, answered
 registered next cycle; updates carry resolved taken branches.
*/
`timescale 1ns/1ps
`include "bdp_params.svh"
module bdp_top #(
   parameter int AW = `BDP_ADDR_W,
   parameter int RAS_DEPTH = `BDP_RAS_DEPTH,
   parameter int BTB_ENTRIES = `BDP_BTB_ENTRIES,
   parameter int TC_ENTRIES = `BDP_TC_ENTRIES
) (
   input wire logic mclk_i,
   input wire logic rst_i,
   input wire bdp_pkg::bdp_req_t req_i,
   input wire bdp_pkg::bdp_upd_t upd_i,
   input wire bdp_pkg::bdp_tc_fill_t tc_fill_i,
   input wire logic tc_flush_i,
   output bdp_pkg::bdp_pred_t pred_o
);
   localparam int TW = $clog2(TC_ENTRIES);
   logic btb_hit;
   logic [AW-1:0] btb_target;
   logic [AW-1:0] ras_top;
   logic ras_empty;
   logic [AW-1:0] fall;
   logic push, pop;
   logic tc_hit;
   logic [AW-1:0] tc_target;
   logic [TC_ENTRIES-1:0] tcv_reg, tcv_next;
   logic [AW-1:0] tc_pc_reg [TC_ENTRIES];
   logic [AW-1:0] tc_tgt_reg [TC_ENTRIES];
   bdp_pkg::bdp_pred_t pred_reg, pred_next;

   function automatic logic [TW-1:0] tc_idx(input logic [AW-1:0] pc);
      tc_idx = pc[TW-1:0];
   endfunction

   function automatic logic [AW-1:0] seq_addr(
      input logic [AW-1:0] pc,
      input logic [`BDP_INSN_LEN_W-1:0] len);
      seq_addr = pc + AW'(len);
   endfunction

   bdp_btb #(
      .ENTRIES(BTB_ENTRIES),
      .AW(AW)
   ) u_btb (
      .mclk_i(mclk_i),
      .rst_i(rst_i),
      .look_pc_i(req_i.pc),
      .hit_o(btb_hit),
      .target_o(btb_target),
      .upd_i(upd_i.valid && upd_i.taken),
      .upd_pc_i(upd_i.pc),
      .upd_target_i(upd_i.target)
   );

   bdp_ras #(
      .DEPTH(RAS_DEPTH),
      .AW(AW)
   ) u_ras (
      .mclk_i(mclk_i),
      .rst_i(rst_i),
      .push_i(push),
      .push_addr_i(fall),
      .pop_i(pop),
      .top_o(ras_top),
      .empty_o(ras_empty)
   );

   assign fall = seq_addr(req_i.pc, req_i.len);
   // Indirect calls push as well: their return comes back to fall
   assign push = req_i.valid && req_i.kind == bdp_pkg::BDP_BR_CALL;
   assign pop = req_i.valid && req_i.kind == bdp_pkg::BDP_BR_RET;

   // Trace-held return targets, valid until flushed or changed
   always_comb begin
      tcv_next = tcv_reg;
      if (tc_flush_i) begin
         tcv_next = '0;
      end
      if (tc_fill_i.valid) begin
         tcv_next[tc_idx(tc_fill_i.pc)] = 1'b1;
      end
   end

   always_ff @(posedge mclk_i) begin
      if (rst_i) begin
         tcv_reg <= '0;
      end else begin
         tcv_reg <= tcv_next;
      end
   end

   always_ff @(posedge mclk_i) begin
      if (tc_fill_i.valid) begin
         tc_pc_reg[tc_idx(tc_fill_i.pc)] <= tc_fill_i.pc;
         tc_tgt_reg[tc_idx(tc_fill_i.pc)] <= tc_fill_i.target;
      end
   end

   assign tc_hit = tcv_reg[tc_idx(req_i.pc)] &&
                   tc_pc_reg[tc_idx(req_i.pc)] == req_i.pc;
   assign tc_target = tc_tgt_reg[tc_idx(req_i.pc)];

   // Prediction select; for conditionals, indirects and indirect calls a buffer hit wins, else the static algorithm
   always_comb begin
      pred_next = '0;
      pred_next.valid = req_i.valid;
      pred_next.target = fall;
      if (req_i.valid) begin
         unique case (req_i.kind)
            bdp_pkg::BDP_BR_NONE: begin
               pred_next.taken = 1'b0;
            end
            bdp_pkg::BDP_BR_COND: begin
               if (btb_hit) begin
                  pred_next.taken = 1'b1;
                  pred_next.target = btb_target;
                  pred_next.from_btb = 1'b1;
               end else if (req_i.direct_target < req_i.pc) begin
                  pred_next.taken = 1'b1;
                  pred_next.target = req_i.direct_target;
               end else begin
                  pred_next.taken = 1'b0;
               end
            end
            bdp_pkg::BDP_BR_UNCOND: begin
               pred_next.taken = 1'b1;
               pred_next.target = req_i.direct_target;
            end
            bdp_pkg::BDP_BR_CALL: begin
               if (req_i.indirect_call) begin
                  if (btb_hit) begin
                     pred_next.taken = 1'b1;
                     pred_next.target = btb_target;
                     pred_next.from_btb = 1'b1;
                  end else begin
                     pred_next.taken = 1'b0;
                  end
               end else begin
                  pred_next.taken = 1'b1;
                  pred_next.target = req_i.direct_target;
               end
            end
            bdp_pkg::BDP_BR_RET: begin
               pred_next.taken = 1'b1;
               if (tc_hit) begin
                  pred_next.target = tc_target;
                  pred_next.from_trace = 1'b1;
               end else if (!ras_empty) begin
                  pred_next.target = ras_top;
                  pred_next.from_ras = 1'b1;
               end else begin
                  // Underflow after deep nesting: best guess only
                  pred_next.taken = 1'b0;
               end
            end
            bdp_pkg::BDP_BR_IND: begin
               if (btb_hit) begin
                  pred_next.taken = 1'b1;
                  pred_next.target = btb_target;
                  pred_next.from_btb = 1'b1;
               end else begin
                  pred_next.taken = 1'b0;
                  pred_next.stop_decode = req_i.next_is_undef;
               end
            end
            default: begin
               pred_next.taken = 1'b0;
            end
         endcase
      end
   end

   always_ff @(posedge mclk_i) begin
      if (rst_i) begin
         pred_reg <= '0;
      end else begin
         pred_reg <= pred_next;
      end
   end

   assign pred_o = pred_reg;

   property p_back_taken;
      @(posedge mclk_i) disable iff (rst_i)
      req_i.valid && req_i.kind == bdp_pkg::BDP_BR_COND && !btb_hit &&
      req_i.direct_target < req_i.pc |=>
         pred_o.taken && pred_o.target == $past(req_i.direct_target);
   endproperty
   a_back_taken: assert property (p_back_taken)
      else $error("Backward miss not predicted taken");

   property p_fwd_fall;
      @(posedge mclk_i) disable iff (rst_i)
      req_i.valid && req_i.kind == bdp_pkg::BDP_BR_COND && !btb_hit &&
      req_i.direct_target >= req_i.pc |=>
         !pred_o.taken && pred_o.target == $past(fall);
   endproperty
   a_fwd_fall: assert property (p_fwd_fall)
      else $error("Forward miss not predicted fall-through");

   property p_miss_no_btb;
      @(posedge mclk_i) disable iff (rst_i)
      req_i.valid && !btb_hit |=> !pred_o.from_btb;
   endproperty
   a_miss_no_btb: assert property (p_miss_no_btb)
      else $error("Prediction claimed from buffer on a miss");

   property p_call_taken;
      @(posedge mclk_i) disable iff (rst_i)
      req_i.valid && req_i.kind == bdp_pkg::BDP_BR_CALL &&
      !req_i.indirect_call |=> pred_o.taken;
   endproperty
   a_call_taken: assert property (p_call_taken)
      else $error("Direct call not predicted taken");

   property p_uncond_taken;
      @(posedge mclk_i) disable iff (rst_i)
      req_i.valid && req_i.kind == bdp_pkg::BDP_BR_UNCOND |=>
         pred_o.taken && pred_o.target == $past(req_i.direct_target);
   endproperty
   a_uncond_taken: assert property (p_uncond_taken)
      else $error("Unconditional branch not predicted taken");

   property p_ind_default;
      @(posedge mclk_i) disable iff (rst_i)
      req_i.valid && req_i.kind == bdp_pkg::BDP_BR_IND && !btb_hit |=>
         !pred_o.taken && pred_o.target == $past(fall);
   endproperty
   a_ind_default: assert property (p_ind_default)
      else $error("Indirect default is not fall-through");

   property p_ind_learned;
      @(posedge mclk_i) disable iff (rst_i)
      upd_i.valid && upd_i.taken ##1
      (req_i.valid && req_i.kind == bdp_pkg::BDP_BR_IND &&
       req_i.pc == $past(upd_i.pc)) |=>
         pred_o.taken && pred_o.target == $past(upd_i.target, 2);
   endproperty
   a_ind_learned: assert property (p_ind_learned)
      else $error("Learned indirect target not used");

   property p_undef_stop;
      @(posedge mclk_i) disable iff (rst_i)
      req_i.valid && req_i.kind == bdp_pkg::BDP_BR_IND && !btb_hit &&
      req_i.next_is_undef |=> pred_o.stop_decode;
   endproperty
   a_undef_stop: assert property (p_undef_stop)
      else $error("Decode not stopped after undefined opcode");

   property p_call_ret;
      @(posedge mclk_i) disable iff (rst_i)
      push ##1 (req_i.valid && req_i.kind == bdp_pkg::BDP_BR_RET &&
                !tc_hit) |=>
         pred_o.from_ras && pred_o.target == $past(fall, 2);
   endproperty
   a_call_ret: assert property (p_call_ret)
      else $error("Return does not target the matching call");

   // A trace hit on a return must take the trace-held target and flag it as from the trace
   property p_ret_trace;
      @(posedge mclk_i) disable iff (rst_i)
      req_i.valid && req_i.kind == bdp_pkg::BDP_BR_RET && tc_hit |=>
         pred_o.taken && pred_o.from_trace &&
         pred_o.target == $past(tc_target);
   endproperty
   a_ret_trace: assert property (p_ret_trace)
      else $error("Trace-held return target not used");

   property p_ret_stack;
      @(posedge mclk_i) disable iff (rst_i)
      req_i.valid && req_i.kind == bdp_pkg::BDP_BR_RET && !tc_hit &&
      !ras_empty |=>
         pred_o.taken && pred_o.from_ras && pred_o.target == $past(ras_top);
   endproperty
   a_ret_stack: assert property (p_ret_stack)
      else $error("Return not taken from the stack top");

   property p_ret_empty;
      @(posedge mclk_i) disable iff (rst_i)
      req_i.valid && req_i.kind == bdp_pkg::BDP_BR_RET && !tc_hit &&
      ras_empty |=>
         !pred_o.taken && pred_o.target == $past(fall);
   endproperty
   a_ret_empty: assert property (p_ret_empty)
      else $error("Return on empty stack not sent to fall-through");

   property p_icall_default;
      @(posedge mclk_i) disable iff (rst_i)
      req_i.valid && req_i.kind == bdp_pkg::BDP_BR_CALL &&
      req_i.indirect_call && !btb_hit |=>
         !pred_o.taken && pred_o.target == $past(fall);
   endproperty
   a_icall_default: assert property (p_icall_default)
      else $error("Indirect call default is not fall-through");

   property p_ind_hit;
      @(posedge mclk_i) disable iff (rst_i)
      req_i.valid && req_i.kind == bdp_pkg::BDP_BR_IND && btb_hit |=>
         pred_o.taken && pred_o.from_btb && !pred_o.stop_decode &&
         pred_o.target == $past(btb_target);
   endproperty
   a_ind_hit: assert property (p_ind_hit)
      else $error("Indirect hit not predicted to learned target");

   property p_cond_hit;
      @(posedge mclk_i) disable iff (rst_i)
      req_i.valid && req_i.kind == bdp_pkg::BDP_BR_COND && btb_hit |=>
         pred_o.taken && pred_o.from_btb &&
         pred_o.target == $past(btb_target);
   endproperty
   a_cond_hit: assert property (p_cond_hit)
      else $error("Conditional hit not predicted from buffer");
endmodule // bdp_top

// ---- bench/bdp_fe_model.sv ----
/*
 Fetch and decode front-end model: issues branch requests, singly or
 back to back, and hands back the prediction that answers each.
 Assumes the predictor answers one cycle after the request edge.
*/
`timescale 1ns/1ps
`include "bdp_params.svh"
module bdp_fe_model (
   input wire logic mclk_i,
   input wire bdp_pkg::bdp_pred_t pred_i,
   output bdp_pkg::bdp_req_t req_o
);
   // Idle from time zero, nothing pending
   initial req_o = '0;

   // Set when the last request was left standing for a chained one
   logic keep = 1'b0;

   // Drive after the falling edge and hold over the taking edge; release
   // with every field inverted so a stale request can never look current;
   // a chained request skips the release and follows on the next edge
   task automatic ask(
      input bdp_pkg::bdp_br_kind_t kind,
      input logic icall,
      input logic [`BDP_ADDR_W-1:0] pc,
      input logic [`BDP_INSN_LEN_W-1:0] len,
      input logic [`BDP_ADDR_W-1:0] tgt,
      input logic undef,
      input logic chain,
      output bdp_pkg::bdp_pred_t p);
      bdp_pkg::bdp_req_t nxt;
      if (!keep) begin
         @(negedge mclk_i);
      end
      req_o <= '{1'b1, kind, icall, pc, len, tgt, undef};
      @(posedge mclk_i);
      @(negedge mclk_i);
      p = pred_i; // Answer stands for this one cycle only
      keep = chain;
      if (!chain) begin
         nxt = bdp_pkg::bdp_req_t'(~req_o);
         nxt.valid = 1'b0;
         req_o <= nxt;
      end
   endtask
endmodule // bdp_fe_model

// ---- bench/bdp_top_bench.sv ----
/*
 Self-checking bench for the branch predictor top.
 Assumes the front-end model answers each request and that updates
 and trace fills are seen by lookups on the following cycle.
*/
`timescale 1ns/1ps
`include "bdp_params.svh"
module bdp_top_bench;
   localparam int AW = `BDP_ADDR_W;
   logic mclk_i = 1'b0;
   logic rst_i = 1'b1;
   bdp_pkg::bdp_req_t req_i;
   bdp_pkg::bdp_upd_t upd_i = '0;
   bdp_pkg::bdp_tc_fill_t tc_fill_i = '0;
   logic tc_flush_i = 1'b0;
   bdp_pkg::bdp_pred_t pred_o;
   bdp_pkg::bdp_pred_t p;
   int fails = 0;
   int n_tests = 0;
   logic chain = 1'b0;

   // 100 MHz core clock
   always #5 mclk_i = ~mclk_i;

   bdp_top bdp_top_inst (
      .mclk_i(mclk_i),
      .rst_i(rst_i),
      .req_i(req_i),
      .upd_i(upd_i),
      .tc_fill_i(tc_fill_i),
      .tc_flush_i(tc_flush_i),
      .pred_o(pred_o)
   );

   bdp_fe_model bdp_fe_model_inst (
      .mclk_i(mclk_i),
      .pred_i(pred_o),
      .req_o(req_i)
   );

   // Verdict and end of run, reached from the main sequence or the watchdog
   task automatic end_sim();
      if (fails == 0 && n_tests > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask

   task automatic check(input logic [63:0] seen, input logic [63:0] exp);
      n_tests++;
      if (seen !== exp) begin
         fails++;
         $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask

   // One request through the model; answer lands in p; chain set keeps
   // the request standing so the next one follows on the very next edge
   task automatic rq(input bdp_pkg::bdp_br_kind_t k, input logic ic,
      input logic [AW-1:0] pc, input logic [3:0] len,
      input logic [AW-1:0] tg, input logic un);
      bdp_fe_model_inst.ask(k, ic, pc, len, tg, un, chain, p);
   endtask

   // Whole-answer compare; src is {buffer, stack, trace, stop}
   task automatic want(input logic tk, input logic [AW-1:0] tg,
      input logic [3:0] src);
      bdp_pkg::bdp_pred_t e;
      e = '{1'b1, tk, tg, src[3], src[2], src[1], src[0]};
      check(64'(p), 64'(e));
   endtask

   // Resolution side: one-cycle update pulse, then scrambled fields
   task automatic upd(input logic [AW-1:0] pc, input logic tk,
      input logic [AW-1:0] tg);
      @(negedge mclk_i);
      upd_i <= '{1'b1, pc, tk, tg};
      @(negedge mclk_i);
      upd_i <= '{1'b0, ~pc, ~tk, ~tg};
   endtask

   // Nest one call past the stack depth so the oldest entry is lost
   task automatic deep_calls(input logic [AW-1:0] base);
      for (int i = 0; i <= `BDP_RAS_DEPTH; i++) begin
         rq(bdp_pkg::BDP_BR_CALL, 1'b0, base + 32'(i * 16), 4'h5,
            32'h8000, 1'b0);
         want(1'b1, 32'h8000, 4'h0);
      end
   endtask

   // Empty stack, then overflow and unwind; only the lost oldest differs
   task automatic s_ras();
      rq(bdp_pkg::BDP_BR_RET, 1'b0, 32'h1000, 4'h1, 32'h0, 1'b0);
      want(1'b0, 32'h1001, 4'h0);
      deep_calls(32'h2000);
      for (int i = `BDP_RAS_DEPTH; i >= 1; i--) begin
         rq(bdp_pkg::BDP_BR_RET, 1'b0, 32'h9000, 4'h1, 32'h0, 1'b0);
         want(1'b1, 32'h2005 + 32'(i * 16), 4'h4);
      end
      rq(bdp_pkg::BDP_BR_RET, 1'b0, 32'h9000, 4'h1, 32'h0, 1'b0);
      want(1'b0, 32'h9001, 4'h0);
   endtask

   // Trace-held return survives an overflowed stack; flush drops it
   task automatic s_trace();
      @(negedge mclk_i);
      tc_fill_i <= '{1'b1, 32'h9100, 32'h7777};
      @(negedge mclk_i);
      tc_fill_i <= '{1'b0, 32'h6eff, 32'h8888};
      deep_calls(32'ha000);
      rq(bdp_pkg::BDP_BR_RET, 1'b0, 32'h9100, 4'h1, 32'h0, 1'b0);
      want(1'b1, 32'h7777, 4'h2);
      @(negedge mclk_i);
      tc_flush_i <= 1'b1;
      @(negedge mclk_i);
      tc_flush_i <= 1'b0;
      rq(bdp_pkg::BDP_BR_RET, 1'b0, 32'h9100, 4'h1, 32'h0, 1'b0);
      want(1'b1, 32'ha0f5, 4'h4);
   endtask

   // Static directions on misses, then a learned conditional
   task automatic s_static();
      rq(bdp_pkg::BDP_BR_COND, 1'b0, 32'h0100, 4'h2, 32'h0080, 1'b0);
      want(1'b1, 32'h0080, 4'h0);
      rq(bdp_pkg::BDP_BR_COND, 1'b0, 32'h0200, 4'h6, 32'h0240, 1'b0);
      want(1'b0, 32'h0206, 4'h0);
      rq(bdp_pkg::BDP_BR_UNCOND, 1'b0, 32'h0300, 4'h2, 32'h0400, 1'b0);
      want(1'b1, 32'h0400, 4'h0);
      upd(32'h0200, 1'b1, 32'h0240);
      rq(bdp_pkg::BDP_BR_COND, 1'b0, 32'h0200, 4'h6, 32'h0240, 1'b0);
      want(1'b1, 32'h0240, 4'h8);
   endtask

   // Indirect default, stop marker, learning and overwrite of one target
   task automatic s_ind();
      rq(bdp_pkg::BDP_BR_IND, 1'b0, 32'h3000, 4'h3, 32'h0, 1'b0);
      want(1'b0, 32'h3003, 4'h0);
      rq(bdp_pkg::BDP_BR_IND, 1'b0, 32'h3000, 4'h3, 32'h0, 1'b1);
      want(1'b0, 32'h3003, 4'h1);
      // Indirect call pushes; the return right behind it must see it
      chain = 1'b1;
      rq(bdp_pkg::BDP_BR_CALL, 1'b1, 32'h3100, 4'h2, 32'h5555, 1'b0);
      chain = 1'b0;
      check(64'(p.target), 64'h3102);
      rq(bdp_pkg::BDP_BR_RET, 1'b0, 32'h3200, 4'h1, 32'h0, 1'b0);
      want(1'b1, 32'h3102, 4'h4);
      // Lookup on the cycle right after the update edge
      fork
         upd(32'h3000, 1'b1, 32'h4000);
         begin
            @(negedge mclk_i);
            rq(bdp_pkg::BDP_BR_IND, 1'b0, 32'h3000, 4'h3, 32'h0, 1'b1);
         end
      join
      want(1'b1, 32'h4000, 4'h8);
      upd(32'h3000, 1'b1, 32'h4800);
      rq(bdp_pkg::BDP_BR_IND, 1'b0, 32'h3000, 4'h3, 32'h0, 1'b0);
      want(1'b1, 32'h4800, 4'h8);
      // A not-taken outcome must leave the taken target alone
      upd(32'h3000, 1'b0, 32'h4c00);
      rq(bdp_pkg::BDP_BR_IND, 1'b0, 32'h3000, 4'h3, 32'h0, 1'b0);
      want(1'b1, 32'h4800, 4'h8);
      rq(bdp_pkg::BDP_BR_IND, 1'b0, 32'h3040, 4'h3, 32'h0, 1'b0);
      want(1'b0, 32'h3043, 4'h0);
   endtask

   // Mid-run reset must forget learned targets and the stack contents
   task automatic s_reset();
      @(negedge mclk_i);
      rst_i <= 1'b1;
      repeat (2) @(negedge mclk_i);
      check(64'(pred_o), 64'h0);
      rst_i <= 1'b0;
      rq(bdp_pkg::BDP_BR_IND, 1'b0, 32'h3000, 4'h3, 32'h0, 1'b0);
      want(1'b0, 32'h3003, 4'h0);
      rq(bdp_pkg::BDP_BR_RET, 1'b0, 32'h3200, 4'h1, 32'h0, 1'b0);
      want(1'b0, 32'h3201, 4'h0);
   endtask

   // Main sequence: reset for ten cycles, then the scenarios
   initial begin
      repeat (10) @(negedge mclk_i);
      rst_i <= 1'b0;
      s_ras();
      s_trace();
      s_static();
      s_ind();
      s_reset();
      end_sim();
   end

   // Watchdog: a hang counts as a mismatch
   initial begin
      repeat (20000) @(posedge mclk_i);
      fails++;
      end_sim();
   end
endmodule // bdp_top_bench
